// file: def_defs.vh
// constants for the dma channel event flag block
//
// Overview of operation
// RULE1 - any-event flag set on error, half or complete; ch3 bit 12, reset 0
// RULE2 - transfer-complete flag set by hardware on completion, else reads 0
// RULE3 - half-transfer flag set by hardware at half point, else reads 0
// RULE4 - transfer-error flag set by hardware on error, else reads 0
// RULE5 - flags stay set until software writes 1 to the clear register bit
// RULE6 - channel 4 has the same four flags with the same behaviour
// RULE7 - clear-register zeros and writes to the status register do nothing
`ifndef DEF_DEFS_VH
`define DEF_DEFS_VH
`define DEF_ADDR_STATUS 4'h0
`define DEF_ADDR_CLEAR 4'h4
`define DEF_CH3_BASE 12
`define DEF_CH4_BASE 16
`define DEF_POS_ANY 0
`define DEF_POS_TC 1
`define DEF_POS_HT 2
`define DEF_POS_TE 3
`define DEF_FLAG_RESET 4'h0
`define DEF_RESP_OKAY 2'h0
`define DEF_RESP_SLVERR 2'h2
`endif

// file: def_event_flags.v
// dma event flag registers for channels 3 and 4, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "def_defs.vh"
module def_event_flags #(
    parameter NUM_CH = 2
) (
    input wire aclk, // 25 MHz system clock
    input wire aresetn, // synchronous reset, active low
    input wire [NUM_CH-1:0] transfer_complete, // per-channel completion pulse
    input wire [NUM_CH-1:0] half_transfer, // per-channel half point pulse
    input wire [NUM_CH-1:0] transfer_error, // per-channel error pulse
    input wire [3:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [3:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output wire [31:0] status_word // live flag word
);
    reg [3:0] flags [0:NUM_CH-1];
    reg aw_held;
    reg [3:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire aw_fire;
    wire w_fire;
    wire wr_go;
    wire [3:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire clr_hit;
    reg [31:0] next_status;
    wire [31:0] clr_word;

    // word-aligned byte address; the two low address bits are ignored
    function [3:0] word_addr;
        input [3:0] addr;
        begin
            word_addr = {addr[3:2], 2'b00};
        end
    endfunction

    // address and data may arrive in either order; each held one deep
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign wr_go = (aw_held || aw_fire) && (w_held || w_fire);
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign clr_hit = wr_go &&
        (word_addr(wr_addr) == `DEF_ADDR_CLEAR); // [RULE7]
    assign clr_word = wr_data & byte_mask(wr_strb);

    function [31:0] byte_mask;
        input [3:0] strb;
        begin
            byte_mask = {{8{strb[3]}}, {8{strb[2]}},
                {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    always @* begin
        next_status = 32'h0000_0000;
        next_status[`DEF_CH3_BASE +: 4] = flags[0];
        if (NUM_CH > 1) begin
            next_status[`DEF_CH4_BASE +: 4] = flags[NUM_CH-1];
        end
    end
    assign status_word = next_status;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch // [RULE6]
            wire [3:0] clr_bits;
            wire [3:0] set_bits;
            wire [3:0] next_flags;
            assign clr_bits = clr_hit ? // [RULE5] [RULE7]
                clr_word[`DEF_CH3_BASE + 4 * ch +: 4] : 4'h0;
            assign set_bits = {transfer_error[ch], half_transfer[ch],
                transfer_complete[ch],
                transfer_error[ch] | half_transfer[ch]
                    | transfer_complete[ch]}; // [RULE1] [RULE2] [RULE3] [RULE4]
            // set beats clear so no event is lost in the clearing cycle
            assign next_flags = (flags[ch] & ~clr_bits) | set_bits; // [RULE5]
            always @(posedge aclk) begin
                if (!aresetn) begin
                    flags[ch] <= `DEF_FLAG_RESET; // [RULE1]
                end else begin
                    flags[ch] <= next_flags;
                end
            end
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DEF_RESP_OKAY;
        end else begin
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // status is read-only: a write there is accepted and ignored
                if (word_addr(wr_addr) == `DEF_ADDR_CLEAR ||
                    word_addr(wr_addr) == `DEF_ADDR_STATUS) begin // [RULE7]
                    s_axi_bresp <= `DEF_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `DEF_RESP_SLVERR;
                end
            end else begin
                if (aw_fire) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_fire) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DEF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (word_addr(s_axi_araddr) == `DEF_ADDR_STATUS) begin
                s_axi_rdata <= next_status;
                s_axi_rresp <= `DEF_RESP_OKAY;
            end else if (word_addr(s_axi_araddr) == `DEF_ADDR_CLEAR) begin
                // clear register is write-only in effect; reads zero
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `DEF_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `DEF_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: def_event_flags_sva.sv
// assertion checker for the dma event flag block
`timescale 1ns/1ps
`default_nettype none
module def_event_flags_chk #(parameter NUM_CH = 2) (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready,
    input wire logic [NUM_CH-1:0] transfer_complete, half_transfer,
    input wire logic [NUM_CH-1:0] transfer_error,
    input wire logic [3:0] s_axi_awaddr, s_axi_wstrb,
    input wire logic [31:0] s_axi_wdata, status_word
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [NUM_CH-1:0] ev;
    assign ev = transfer_complete | half_transfer | transfer_error;
    wire logic cl = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && s_axi_awaddr == 4'h4;
    wire logic [7:0] m = cl ? s_axi_wdata[19:12] : 8'h00;
    // set wins over clear, so a clear is judged only in a quiet cycle
    sequence s_clr; cl && s_axi_wstrb == 4'hF && ev == '0; endsequence
    property p_any; ev[0] |=> status_word[12]; endproperty
    a_any: assert property (p_any) else $error("ch3 any flag");
    property p_tc; transfer_complete[0] |=> status_word[13]; endproperty
    a_tc: assert property (p_tc) else $error("ch3 done flag");
    property p_ht; half_transfer[0] |=> status_word[14]; endproperty
    a_ht: assert property (p_ht) else $error("ch3 half flag");
    property p_te; transfer_error[0] |=> status_word[15]; endproperty
    a_te: assert property (p_te) else $error("ch3 error flag");
    property p_keep; 1'b1 |=> &(status_word[19:12] | $past(m) |
        ~$past(status_word[19:12])); endproperty
    a_keep: assert property (p_keep) else $error("lost");
    property p_clr; s_clr |=>
        !(|(status_word[19:12] & $past(s_axi_wdata[19:12]))); endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_ch4; ev[1] |=> status_word[16] && &(status_word[19:17] |
        ~$past({transfer_error[1], half_transfer[1],
        transfer_complete[1]})); endproperty
    a_ch4: assert property (p_ch4) else $error("ch4 flags");
endmodule
bind def_event_flags def_event_flags_chk #(.NUM_CH(NUM_CH)) u_chk (.*);
`default_nettype wire

// file: dma_channel_event_flags_test.sv
// self-checking bench for the dma event flag block
`timescale 1ns/1ps
`default_nettype none
module dma_channel_event_flags_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] cpl, hlf, err, bresp, rresp;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, e, sw;
    logic [33:0] q[$];
    int bad_count, compares, i, n;
    def_event_flags uut (.aclk(aclk), .aresetn(aresetn),
        .transfer_complete(cpl), .half_transfer(hlf), .transfer_error(err),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .status_word(sw));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task check(input logic [33:0] got, exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (rvalid && rready)
            check({rresp, rdata}, q.pop_front());
        if (bvalid && bready)
            check({bresp, 32'h0}, q.pop_front());
    end
    // one task for both directions; for a read d is the expected word
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge aclk);
        q.push_back({r, w ? 32'h0 : d});
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid || rvalid) break;
        end
        {bready, rready} <= 2'h0;
        if (n == 50) begin
            bad_count++;
            conclude();
        end
    endtask
    initial begin
        void'($urandom(5));
        {awvalid, wvalid, bready, arvalid, rready, cpl, hlf, err} <= 11'h0;
        {awaddr, araddr, wdata} <= 40'h0;
        wstrb <= 4'hF;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        bus(0, 4'h0, 32'h0, 2'h0);
        bus(0, 4'h8, 32'h0, 2'h2);
        bus(1, 4'hC, 32'hFFFFFFFF, 2'h2);
        for (i = 0; i < 10; i++) begin
            @(posedge aclk);
            {err, hlf, cpl} <= (i < 6) ? 6'h01 << i : 6'($urandom);
            @(posedge aclk);
            {err, hlf, cpl} <= 6'h00;
            e = 32'h0;
            for (n = 0; n < 2; n++)
                e |= {28'h0, err[n], hlf[n], cpl[n],
                    err[n] | hlf[n] | cpl[n]} << (12 + 4 * n);
            bus(0, 4'h0, e, 2'h0);
            check({2'h0, sw}, {2'h0, e});
            bus(1, 4'h0, 32'hFFFFFFFF, 2'h0);
            bus(1, 4'h4, ~e & $urandom, 2'h0);
            bus(0, 4'h0, e, 2'h0);
            // byte 1 strobe alone clears only the channel 3 flags
            wstrb <= 4'h2;
            bus(1, 4'h4, e, 2'h0);
            wstrb <= 4'hF;
            bus(0, 4'h0, e & 32'h000F_0000, 2'h0);
            bus(1, 4'h4, e, 2'h0);
            bus(0, 4'h0, 32'h0, 2'h0);
        end
        conclude();
    end
endmodule
`default_nettype wire
